// ===== verilog/uaf_pkg.sv
// constants, offsets and state codes for one fifo-access and fractional baud channel
// assumes a 4 kbyte channel map: address bits 11:10 select the channel
package uaf_pkg;
  localparam int          ADDR_W         = 16;
  localparam int          REL_W          = 10;
  localparam int          FIFO_DEPTH     = 256;
  localparam int          RX_W           = 16;
  localparam int          TX_W           = 8;
  localparam int          CNT_W          = 9;
  // channel-relative offsets
  localparam logic [9:0]  HOLD_OFS       = 10'h000;
  localparam logic [9:0]  DIV_WORD_OFS   = 10'h010;
  localparam logic [9:0]  MODE_WORD_OFS  = 10'h014;
  localparam logic [1:0]  BURST_WIN_SEL  = 2'h1;
  localparam logic [1:0]  CHAN_TOP_ZERO  = 2'h0;
  // mode word and modem control field positions
  localparam int          EIGHT_BIT_POS  = 0;
  localparam int          FOUR_BIT_POS   = 1;
  localparam int          PRESCALE_POS   = 7;
  // reset values
  localparam logic [7:0]  DIV_LOW_RST    = 8'h01;
  localparam logic [7:0]  DIV_HIGH_RST   = 8'h00;
  localparam logic [3:0]  DIV_FRAC_RST   = 4'h0;
  localparam logic [7:0]  MODEM_CTL_RST  = 8'h00;
  // prescaler and oversampling counts
  localparam logic [1:0]  PRESCALE_LAST  = 2'h3;
  localparam logic [3:0]  OVS16_LAST     = 4'hf;
  localparam logic [3:0]  OVS8_LAST      = 4'h7;
  localparam logic [3:0]  OVS4_LAST      = 4'h3;
  localparam logic [16:0] PERIOD_RST     = 17'h00001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_STEP = 3'b010,
    ST_DONE = 3'b100
  } uaf_state_type;
endpackage : uaf_pkg

// ===== verilog/uaf_fifo.sv
// synchronous fifo with valid/ready on both sides and an occupancy count
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module uaf_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_srst,
  input  wire logic          i_push_valid,
  input  wire logic [W-1:0]  i_push_data,
  output logic               o_push_ready,
  output logic               o_pop_valid,
  output logic [W-1:0]       o_pop_data,
  input  wire logic          i_pop_ready,
  output logic [AW:0]        o_count
);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr_ff;
  logic [AW:0]  rd_ptr_ff;
  wire          push_fire = i_push_valid && o_push_ready;
  wire          pop_fire  = o_pop_valid && i_pop_ready;
  wire          is_empty  = (wr_ptr_ff == rd_ptr_ff);
  wire          is_full   = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) &&
                            (wr_ptr_ff[AW] != rd_ptr_ff[AW]);

  assign o_push_ready = !is_full;
  assign o_pop_valid  = !is_empty;
  assign o_pop_data   = mem[rd_ptr_ff[AW-1:0]];
  assign o_count      = wr_ptr_ff - rd_ptr_ff;

  always_ff @(posedge i_ref_clk) begin
    if (push_fire) begin
      mem[wr_ptr_ff[AW-1:0]] <= i_push_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push_fire) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop_fire)  rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule : uaf_fifo

// ===== verilog/uaf_channel.sv
// one uart channel: host fifo windows, holding registers, fractional baud generator
// assumes a held bus request answered by a one-cycle ack; serial side on the same clock
`timescale 1ns/10ps

// Summary of operation
// - paired window gives status then data bytes
// - 128 dword reads empty a full fifo with status
// - tx burst writes queue lanes zero upward
// - holding address writes tx, reads rx
// - rx holding reachable at 0x400 channel stride
// - private 256-entry tx and rx fifos
// - modem control bit 7 prescales by four
// - divisor one to 65536 minus 1/16
// - sampling tick leaves as an output; the tx and rx fifos do not use it
// - divisor resets to one
// - sixteen-bit integer plus four-bit fraction
// - prescaler on quarters the serial rate
// - 8x doubles, 4x quadruples the rate
// - odd fraction jitter tolerated in 8x/4x
// - both sampling controls clear means 16x
module uaf_channel
  import uaf_pkg::*;
#(
  parameter logic [1:0] CHAN_ID = 2'h0
) (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_srst,
  input  wire logic                    i_bus_req,
  input  wire logic                    i_bus_we,
  input  wire logic [uaf_pkg::ADDR_W-1:0] i_bus_addr,
  input  wire logic [3:0]              i_bus_be,
  input  wire logic [31:0]             i_bus_wdata,
  output logic                         o_bus_ack,
  output logic [31:0]                  o_bus_rdata,
  input  wire logic                    i_rx_valid,
  input  wire logic [7:0]              i_rx_data,
  input  wire logic [7:0]              i_rx_line_status,
  output logic                         o_rx_ready,
  output logic                         o_tx_valid,
  output logic [7:0]                   o_tx_data,
  input  wire logic                    i_tx_ready,
  output logic                         o_sample_tick,
  output logic                         o_bit_tick
);
  import uaf_pkg::*;

  uaf_state_type     state_ff;
  uaf_state_type     nxt_state;
  logic [ADDR_W-1:0] addr_ff;
  logic [3:0]        be_ff;
  logic              we_ff;
  logic [31:0]       wdata_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        lane_ff;
  logic [7:0]        div_low_ff;
  logic [7:0]        div_high_ff;
  logic [3:0]        div_frac_ff;
  logic [7:0]        modem_control_ff;
  logic              eight_times_sampling_ff;
  logic              four_times_sampling_ff;
  logic [1:0]        pre_cnt_ff;
  logic [16:0]       cnt_ff;
  logic [16:0]       period_ff;
  logic [3:0]        acc_ff;
  logic [3:0]        samp_cnt_ff;
  logic              sample_tick_ff;
  logic              bit_tick_ff;

  // address decode of the request being taken
  wire         take         = (state_ff == ST_IDLE) && i_bus_req;
  wire         take_chan    = (i_bus_addr[15:12] == 4'h0) && (i_bus_addr[11:10] == CHAN_ID);
  wire         take_div     = take_chan && (i_bus_addr[9:2] == DIV_WORD_OFS[9:2]);
  wire         take_mode    = take_chan && (i_bus_addr[9:2] == MODE_WORD_OFS[9:2]);
  wire [31:0]  div_word     = {modem_control_ff, 4'h0, div_frac_ff, div_high_ff, div_low_ff};
  wire [31:0]  mode_word    = {30'h0, four_times_sampling_ff, eight_times_sampling_ff};
  wire [31:0]  reg_rdata    = take_div ? div_word : (take_mode ? mode_word : 32'h0);

  // decode of the latched request
  wire         chan_hit     = (addr_ff[15:12] == 4'h0) && (addr_ff[11:10] == CHAN_ID);
  wire         hold_hit     = chan_hit && (addr_ff[9:2] == HOLD_OFS[9:2]);
  wire         burst_hit    = chan_hit && (addr_ff[9:8] == BURST_WIN_SEL);
  wire         pair_hit     = chan_hit && addr_ff[9];
  wire         div_hit      = chan_hit && (addr_ff[9:2] == DIV_WORD_OFS[9:2]);
  wire         pair_lane    = (lane_ff[0] == 1'b0) &&
                              (be_ff[lane_ff] || be_ff[{lane_ff[1], 1'b1}]);
  // holding path is byte wide, so only lane 0 moves data there
  wire         byte_lane    = be_ff[lane_ff] && (burst_hit || (hold_hit && lane_ff == 2'h0));
  wire         lane_act     = we_ff ? (byte_lane && !pair_hit)
                                    : (pair_hit ? pair_lane : byte_lane);
  wire         in_step      = (state_ff == ST_STEP);

  // fifo handshakes
  wire         rx_pop_valid;
  wire [15:0]  rx_pop_data;
  wire [CNT_W-1:0] rx_count;
  wire         rx_pop_ready = in_step && !we_ff && lane_act;
  wire         tx_push_valid = in_step && we_ff && lane_act;
  wire         tx_push_ready;
  wire [7:0]   tx_push_data = wdata_ff[8*lane_ff +: 8];
  wire [CNT_W-1:0] tx_count;
  // writes wait on a full fifo; reads of an empty fifo return zero rather than hang
  wire         lane_done    = !lane_act || !we_ff || tx_push_ready;
  wire [15:0]  rx_word      = rx_pop_valid ? rx_pop_data : 16'h0;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = i_bus_req ? ST_STEP : ST_IDLE;
      ST_STEP: nxt_state = (lane_done && lane_ff == 2'h3) ? ST_DONE : ST_STEP;
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_ff <= ST_IDLE;
      lane_ff  <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      if (take) lane_ff <= 2'h0;
      else if (in_step && lane_done) lane_ff <= lane_ff + 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      addr_ff  <= '0;
      be_ff    <= 4'h0;
      we_ff    <= 1'b0;
      wdata_ff <= 32'h0;
    end else if (take) begin
      addr_ff  <= i_bus_addr;
      be_ff    <= i_bus_be;
      we_ff    <= i_bus_we;
      wdata_ff <= i_bus_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rdata_ff <= 32'h0;
    end else if (take) begin
      rdata_ff <= i_bus_we ? 32'h0 : reg_rdata;
    end else if (rx_pop_ready && pair_hit) begin
      rdata_ff[16*lane_ff[1] +: 16] <= rx_word;
    end else if (rx_pop_ready) begin
      rdata_ff[8*lane_ff +: 8] <= rx_word[15:8];
    end
  end

  // divisor, modem control and sampling mode registers
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      div_low_ff              <= DIV_LOW_RST;
      div_high_ff             <= DIV_HIGH_RST;
      div_frac_ff             <= DIV_FRAC_RST;
      modem_control_ff        <= MODEM_CTL_RST;
      eight_times_sampling_ff <= 1'b0;
      four_times_sampling_ff  <= 1'b0;
    end else if (take && i_bus_we) begin
      if (take_div && i_bus_be[0]) div_low_ff       <= i_bus_wdata[7:0];
      if (take_div && i_bus_be[1]) div_high_ff      <= i_bus_wdata[15:8];
      if (take_div && i_bus_be[2]) div_frac_ff      <= i_bus_wdata[19:16];
      if (take_div && i_bus_be[3]) modem_control_ff <= i_bus_wdata[31:24];
      if (take_mode && i_bus_be[0]) begin
        eight_times_sampling_ff <= i_bus_wdata[EIGHT_BIT_POS];
        four_times_sampling_ff  <= i_bus_wdata[FOUR_BIT_POS];
      end
    end
  end

  assign o_bus_ack   = (state_ff == ST_DONE);
  assign o_bus_rdata = rdata_ff;

  uaf_fifo #(.W(RX_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_ref_clk    (i_ref_clk),
    .i_srst       (i_srst),
    .i_push_valid (i_rx_valid),
    .i_push_data  ({i_rx_data, i_rx_line_status}),
    .o_push_ready (o_rx_ready),
    .o_pop_valid  (rx_pop_valid),
    .o_pop_data   (rx_pop_data),
    .i_pop_ready  (rx_pop_ready),
    .o_count      (rx_count)
  );

  uaf_fifo #(.W(TX_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .i_ref_clk    (i_ref_clk),
    .i_srst       (i_srst),
    .i_push_valid (tx_push_valid),
    .i_push_data  (tx_push_data),
    .o_push_ready (tx_push_ready),
    .o_pop_valid  (o_tx_valid),
    .o_pop_data   (o_tx_data),
    .i_pop_ready  (i_tx_ready),
    .o_count      (tx_count)
  );

  // baud generator
  wire         prescale   = modem_control_ff[PRESCALE_POS];
  wire         pre_tick   = !prescale || (pre_cnt_ff == PRESCALE_LAST);
  wire [15:0]  div_int    = {div_high_ff, div_low_ff};
  // a zero integer divisor is treated as one
  wire [15:0]  eff_int    = (div_int == 16'h0) ? 16'h0001 : div_int;
  wire [4:0]   frac_sum   = {1'b0, acc_ff} + {1'b0, div_frac_ff};
  wire [16:0]  period_nxt = {1'b0, eff_int} + {16'h0, frac_sum[4]};
  wire         terminal   = pre_tick && (cnt_ff >= period_ff);
  // one stretched period every carry gives the n/16 average; jitter is inherent
  wire [3:0]   ovs_last   = eight_times_sampling_ff ? OVS8_LAST :
                            (four_times_sampling_ff ? OVS4_LAST : OVS16_LAST);
  wire         bit_end    = terminal && (samp_cnt_ff >= ovs_last);

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pre_cnt_ff     <= 2'h0;
      cnt_ff         <= PERIOD_RST;
      period_ff      <= PERIOD_RST;
      acc_ff         <= 4'h0;
      samp_cnt_ff    <= 4'h0;
      sample_tick_ff <= 1'b0;
      bit_tick_ff    <= 1'b0;
    end else begin
      pre_cnt_ff     <= pre_cnt_ff + 2'h1;
      sample_tick_ff <= terminal;
      bit_tick_ff    <= bit_end;
      if (terminal) begin
        cnt_ff      <= PERIOD_RST;
        period_ff   <= period_nxt;
        acc_ff      <= frac_sum[3:0];
        samp_cnt_ff <= bit_end ? 4'h0 : samp_cnt_ff + 4'h1;
      end else if (pre_tick) begin
        cnt_ff <= cnt_ff + 17'h1;
      end
    end
  end

  assign o_sample_tick = sample_tick_ff;
  assign o_bit_tick    = bit_tick_ff;

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  wire rx_push_fire = i_rx_valid && o_rx_ready;
  wire tx_pop_fire  = o_tx_valid && i_tx_ready;

  property p_div_reset;
    $fell(i_srst) |->
      div_low_ff == DIV_LOW_RST && div_high_ff == DIV_HIGH_RST && div_frac_ff == DIV_FRAC_RST;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divisor not one after reset");

  property p_frac_upper;
    (o_bus_ack && !we_ff && div_hit) |-> o_bus_rdata[23:20] == 4'h0;
  endproperty
  a_frac_upper: assert property (p_frac_upper) else $error("fraction upper bits set");

  property p_bypass;
    !prescale |-> pre_tick;
  endproperty
  a_bypass: assert property (p_bypass) else $error("prescaler bypass missed a tick");

  property p_quarter;
    (prescale && pre_tick) |=> (!pre_tick || !prescale)[*3];
  endproperty
  a_quarter: assert property (p_quarter) else $error("prescaler not dividing by four");

  property p_period_next;
    terminal |=> (period_ff == {1'b0, $past(eff_int)}) ||
                 (period_ff == {1'b0, $past(eff_int)} + 17'h1);
  endproperty
  a_period_next: assert property (p_period_next) else $error("period outside divisor");

  property p_frac_zero;
    (terminal && div_frac_ff == 4'h0 && acc_ff == 4'h0) |=> period_ff == {1'b0, $past(eff_int)};
  endproperty
  a_frac_zero: assert property (p_frac_zero) else $error("period stretched without fraction");

  property p_ovs16;
    (!eight_times_sampling_ff && !four_times_sampling_ff) |-> ovs_last == 4'hf;
  endproperty
  a_ovs16: assert property (p_ovs16) else $error("default sampling not 16x");

  property p_bit_tick;
    bit_tick_ff |-> sample_tick_ff;
  endproperty
  a_bit_tick: assert property (p_bit_tick) else $error("bit tick without sample tick");

  property p_read_ack;
    (take && !i_bus_we) |-> ##5 o_bus_ack;
  endproperty
  a_read_ack: assert property (p_read_ack) else $error("read not answered in five cycles");

  property p_rx_pop;
    (rx_pop_ready && rx_pop_valid) |=>
      rx_count == $past(rx_count) - 9'h1 + {8'h0, $past(rx_push_fire)};
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("rx entry not removed");

  property p_tx_push;
    (tx_push_valid && tx_push_ready) |=>
      tx_count == $past(tx_count) + 9'h1 - {8'h0, $past(tx_pop_fire)};
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("tx entry not added");

  property p_hold_byte;
    (o_bus_ack && !we_ff && hold_hit) |-> o_bus_rdata[31:8] == 24'h0;
  endproperty
  a_hold_byte: assert property (p_hold_byte) else $error("holding read wider than a byte");

  c_pair_read:  cover property (o_bus_ack && !we_ff && pair_hit && be_ff == 4'hf);
  c_tx_burst:   cover property (o_bus_ack && we_ff && burst_hit && be_ff == 4'hf);
  c_pre_bit:    cover property (prescale && bit_tick_ff);
  c_frac_carry: cover property (terminal && frac_sum[4]);
endmodule : uaf_channel

// ===== dv/uaf_far_model.sv
// serial-side stand-in: feeds received bytes with status, sinks transmitted bytes
// assumes the channel's clock and synchronous reset; bench calls send()
`timescale 1ns/10ps
module uaf_far_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  input  wire logic       i_stall,
  input  wire logic       i_rx_ready,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic [7:0]      o_rx_line_status,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready
);
  logic [7:0] tx_log[$];
  logic [3:0] pace;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_line_status = 8'h00;
    o_tx_ready = 1'b0;
    pace = 4'h5;
  end

  // ready comes and goes, so the sink is both prompt and slow
  always @(posedge i_ref_clk) begin
    pace <= {pace[2:0], pace[3] ^ pace[2]};
    o_tx_ready <= !i_stall && !i_srst && pace[0];
    if (i_tx_valid && o_tx_ready) begin
      tx_log.push_back(i_tx_data);
    end
  end

  // released lines show the inverse so a stale byte never looks valid
  task send(input logic [7:0] d, input logic [7:0] s);
    @(posedge i_ref_clk);
    o_rx_valid <= 1'b1;
    o_rx_data <= d;
    o_rx_line_status <= s;
    do @(negedge i_ref_clk); while (i_rx_ready !== 1'b1);
    @(posedge i_ref_clk);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~d;
    o_rx_line_status <= ~s;
  endtask : send
endmodule : uaf_far_model

// ===== dv/testbench.sv
// self-checking bench for one channel: register bus, fifo windows, baud ticks
// assumes the serial side model and channel 0 at the low 1 kbyte
`timescale 1ns/10ps
module testbench;
  import uaf_pkg::*;
  logic        clk, srst, req, we, stall, rx_v, rx_rdy, tx_v, tx_rdy, ack, st, bt;
  logic [15:0] addr;
  logic [3:0]  be;
  logic [31:0] wdata, rdata, rd, rnd;
  logic [7:0]  rx_d, rx_s, tx_d;
  logic [15:0] rxq[$];
  logic [7:0]  txq[$];
  int          miscompares, samples_checked, cyc, cs, cb, es, eb;
  int          ci[6] = '{1, 3, 2, 5, 2, 0};
  int          cf[6] = '{0, 8, 0, 1, 0, 0};
  int          cp[6] = '{1, 1, 4, 1, 1, 1};
  int          cm[6] = '{0, 0, 1, 2, 3, 0};

  uaf_channel #(.CHAN_ID(2'h0)) u_dut (.i_ref_clk(clk), .i_srst(srst), .i_bus_req(req),
    .i_bus_we(we), .i_bus_addr(addr), .i_bus_be(be), .i_bus_wdata(wdata), .o_bus_ack(ack),
    .o_bus_rdata(rdata), .i_rx_valid(rx_v), .i_rx_data(rx_d), .i_rx_line_status(rx_s),
    .o_rx_ready(rx_rdy), .o_tx_valid(tx_v), .o_tx_data(tx_d), .i_tx_ready(tx_rdy),
    .o_sample_tick(st), .o_bit_tick(bt));
  uaf_far_model u_far (.i_ref_clk(clk), .i_srst(srst), .i_stall(stall), .i_rx_ready(rx_rdy),
    .o_rx_valid(rx_v), .o_rx_data(rx_d), .o_rx_line_status(rx_s), .i_tx_valid(tx_v),
    .i_tx_data(tx_d), .o_tx_ready(tx_rdy));

  function automatic logic [31:0] nxt_rand(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : nxt_rand

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task results;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // request held until the ack is seen, dropped at the edge closing the ack cycle
  task bus(input logic w, input logic [15:0] a, input logic [3:0] b, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    addr <= a;
    be <= b;
    wdata <= d;
    do begin
      @(negedge clk);
      n++;
    end while (ack !== 1'b1 && n < 400);
    rd = rdata;
    if (n >= 400) check("bus ack", 32'h0, 32'h1);
    @(posedge clk);
    req <= 1'b0;
  endtask : bus

  task push_rx(input int n);
    repeat (n) begin
      rnd = nxt_rand(rnd);
      rxq.push_back(rnd[15:0]);
      u_far.send(rnd[15:8], rnd[7:0]);
    end
  endtask : push_rx

  // expected burst-window word: one data byte per enabled lane, lane 0 first
  task burst_rd(input logic [3:0] b);
    logic [31:0] e;
    e = 32'h0;
    for (int k = 0; k < 4; k++) begin
      if (b[k] && rxq.size() > 0) e[8*k +: 8] = 8'(rxq.pop_front() >> 8);
    end
    bus(1'b0, 16'h0100, b, 32'h0);
    check("burst read", rd, e);
  endtask : burst_rd

  task burst_wr(input logic [3:0] b);
    rnd = nxt_rand(rnd);
    for (int k = 0; k < 4; k++) if (b[k]) txq.push_back(rnd[8*k +: 8]);
    bus(1'b1, 16'h0100, b, rnd);
  endtask : burst_wr

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    srst = 1'b1;
    req = 1'b0;
    we = 1'b0;
    addr = 16'h0;
    be = 4'h0;
    wdata = 32'h0;
    stall = 1'b0;
    rnd = 32'hc4b7;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, 16'h0010, 4'hf, 32'h0);
    check("divisor word", rd, 32'h00000001);
    bus(1'b0, 16'h0014, 4'hf, 32'h0);
    check("mode word", rd, 32'h0);
    check("rx ready", rx_rdy, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rnd = nxt_rand(rnd);
      bus(1'b1, 16'h0010, 4'hf, rnd);
      bus(1'b0, 16'h0010, 4'hf, 32'h0);
      check("divisor readback", rd, rnd & 32'hff0fffff);
    end
    // the random divisors above leave a long period running; a reset restarts it
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, 16'h0010, 4'hf, 32'h0);
    check("divisor after reset", rd, 32'h00000001);
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, 16'h0010, 4'hf,
          {(cp[k] == 4) ? 8'h80 : 8'h00, 4'h0, 4'(cf[k]), 16'(ci[k])});
      bus(1'b1, 16'h0014, 4'hf, 32'(cm[k]));
      repeat (200) @(posedge clk);
      cs = 0;
      cb = 0;
      repeat (1600) begin
        @(negedge clk);
        cs += int'(st);
        cb += int'(bt);
      end
      es = 1600 * 16 / (cp[k] * ((ci[k] == 0 ? 1 : ci[k]) * 16 + cf[k]));
      eb = es / (cm[k][0] ? 8 : (cm[k][1] ? 4 : 16));
      check("sample ticks", 32'(cs >= es - 2 && cs <= es + 2), 32'h1);
      check("bit ticks", 32'(cb >= eb - 2 && cb <= eb + 2), 32'h1);
    end
    push_rx(64);
    for (int i = 0; i < 32; i++) begin
      bus(1'b0, 16'h0200, 4'hf, 32'h0);
      check("paired read", rd, {rxq[1], rxq[0]});
      void'(rxq.pop_front());
      void'(rxq.pop_front());
    end
    bus(1'b0, 16'h0200, 4'hf, 32'h0);
    check("paired read empty", rd, 32'h0);
    push_rx(256);
    @(negedge clk);
    check("rx full", rx_rdy, 1'b0);
    bus(1'b0, 16'h0410, 4'hf, 32'h0);
    check("foreign channel", rd, 32'h0);
    bus(1'b0, 16'h3000, 4'h1, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b0, 16'h0000, 4'h1, 32'h0);
    check("holding read", rd, {24'h0, 8'(rxq.pop_front() >> 8)});
    repeat (63) burst_rd(4'hf);
    burst_rd(4'h7);
    burst_rd(4'hf);
    stall <= 1'b1;
    rnd = nxt_rand(rnd);
    txq.push_back(rnd[7:0]);
    bus(1'b1, 16'h0000, 4'h1, rnd);
    bus(1'b1, 16'h0200, 4'hf, 32'h5a5a5a5a);
    repeat (63) burst_wr(4'hf);
    burst_wr(4'h7);
    check("tx held", tx_v, 1'b1);
    stall <= 1'b0;
    for (int i = 0; i < 3000 && u_far.tx_log.size() < 256; i++) @(posedge clk);
    repeat (20) @(posedge clk);
    check("tx count", u_far.tx_log.size(), 32'd256);
    for (int i = 0; i < 256 && i < u_far.tx_log.size(); i++) begin
      check("tx byte", u_far.tx_log[i], txq[i]);
    end
    results();
  end
endmodule : testbench
